// [verilog/bdpm_pkg.sv]
`default_nettype none
package bdpm_pkg;

  // Lane geometry of the shared data bus.
  localparam int unsigned BDPM_LANES = 16;
  localparam int unsigned BDPM_BYTE = 8;

  // Mode select codes on the mode input.
  localparam logic [2:0] BDPM_SEL_SYNC_SPLIT = 3'h0;
  localparam logic [2:0] BDPM_SEL_ASYNC_SPLIT = 3'h1;
  localparam logic [2:0] BDPM_SEL_MIXED = 3'h2;
  localparam logic [2:0] BDPM_SEL_SYNC_BI8 = 3'h3;
  localparam logic [2:0] BDPM_SEL_HSK8 = 3'h4;
  localparam logic [2:0] BDPM_SEL_ASYNC_FULL = 3'h5;
  localparam logic [2:0] BDPM_SEL_SYNC_BI16 = 3'h6;
  localparam logic [2:0] BDPM_SEL_HSK16 = 3'h7;

  // Values after reset.
  localparam logic [15:0] BDPM_WORD_RST = 16'h0000;
  localparam logic [15:0] BDPM_OE_RST = 16'h0000;
  localparam logic BDPM_FLAG_RST = 1'b0;
  localparam logic BDPM_STROBE_IDLE = 1'b1;

  // Lane groups that a mode may drive.
  localparam logic [15:0] BDPM_LOW_LANES = 16'h00ff;
  localparam logic [15:0] BDPM_HIGH_LANES = 16'hff00;
  localparam logic [15:0] BDPM_ALL_LANES = 16'hffff;

  typedef enum logic [7:0] {
    BDPM_M_SYNC_SPLIT = 8'h01,
    BDPM_M_ASYNC_SPLIT = 8'h02,
    BDPM_M_MIXED = 8'h04,
    BDPM_M_SYNC_BI8 = 8'h08,
    BDPM_M_HSK8 = 8'h10,
    BDPM_M_ASYNC_FULL = 8'h20,
    BDPM_M_SYNC_BI16 = 8'h40,
    BDPM_M_HSK16 = 8'h80
  } bdpm_mode_type;

  function automatic bdpm_mode_type bdpm_decode_mode(input logic [2:0] sel);
    bdpm_mode_type m;
    m = BDPM_M_SYNC_SPLIT;
    case (sel)
      BDPM_SEL_SYNC_SPLIT: m = BDPM_M_SYNC_SPLIT;
      BDPM_SEL_ASYNC_SPLIT: m = BDPM_M_ASYNC_SPLIT;
      BDPM_SEL_MIXED: m = BDPM_M_MIXED;
      BDPM_SEL_SYNC_BI8: m = BDPM_M_SYNC_BI8;
      BDPM_SEL_HSK8: m = BDPM_M_HSK8;
      BDPM_SEL_ASYNC_FULL: m = BDPM_M_ASYNC_FULL;
      BDPM_SEL_SYNC_BI16: m = BDPM_M_SYNC_BI16;
      BDPM_SEL_HSK16: m = BDPM_M_HSK16;
      default: m = BDPM_M_SYNC_SPLIT;
    endcase
    return m;
  endfunction : bdpm_decode_mode

  // Converts a pin level to an asserted flag under a polarity bit (1 = active high).
  function automatic logic bdpm_asserted(input logic pin, input logic pol);
    return ~(pin ^ pol);
  endfunction : bdpm_asserted

endpackage : bdpm_pkg
`default_nettype wire

// [verilog/bdpm_pin_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bdpm_pin_if;
  logic pclk_rise;
  logic ien_act;
  logic ien_rise;
  logic oen_act;
  logic oen_rise;
  logic wr_fall;
  logic rd_fall;
  logic [15:0] lanes;

  modport front (
    output pclk_rise, ien_act, ien_rise, oen_act, oen_rise, wr_fall, rd_fall, lanes
  );
  modport core (
    input pclk_rise, ien_act, ien_rise, oen_act, oen_rise, wr_fall, rd_fall, lanes
  );
endinterface : bdpm_pin_if
`default_nettype wire

// [verilog/bdpm_pin_front.sv]
`timescale 1ns/1ps
`default_nettype none
module bdpm_pin_front
  import bdpm_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Port pins and polarity selects.
  input wire logic port_input_clock,
  input wire logic input_strobe_enable,
  input wire logic output_strobe_enable,
  input wire logic handshake_write_strobe,
  input wire logic handshake_read_strobe,
  input wire logic [15:0] port_data_lanes_in,
  input wire logic out_enable_polarity_bit,
  input wire logic in_enable_polarity_bit,
  // Decoded pin events.
  bdpm_pin_if.front pins
);

  logic pclk_q, pclk_prev_q;
  logic ien_q, ien_prev_q;
  logic oen_q, oen_prev_q;
  logic wr_q, wr_prev_q;
  logic rd_q, rd_prev_q;
  logic [15:0] lanes_q;

  // Samples and one-cycle history; data is sampled with the strobes so they stay aligned.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {pclk_q, pclk_prev_q} <= 2'h0;
      {ien_q, ien_prev_q, oen_q, oen_prev_q} <= 4'h0;
      {wr_q, wr_prev_q, rd_q, rd_prev_q} <= {4{BDPM_STROBE_IDLE}};
      lanes_q <= BDPM_WORD_RST;
    end
    else
    begin
      {pclk_prev_q, pclk_q} <= {pclk_q, port_input_clock};
      {ien_prev_q, ien_q} <= {ien_q, bdpm_asserted(input_strobe_enable, in_enable_polarity_bit)};
      {oen_prev_q, oen_q} <= {oen_q, bdpm_asserted(output_strobe_enable, out_enable_polarity_bit)};
      {wr_prev_q, wr_q} <= {wr_q, handshake_write_strobe};
      {rd_prev_q, rd_q} <= {rd_q, handshake_read_strobe};
      lanes_q <= port_data_lanes_in;
    end
  end

  assign pins.pclk_rise = pclk_q & ~pclk_prev_q;
  assign pins.ien_act = ien_q;
  assign pins.ien_rise = ien_q & ~ien_prev_q;
  assign pins.oen_act = oen_q;
  assign pins.oen_rise = oen_q & ~oen_prev_q;
  // Handshake strobes act on their falling edge.
  assign pins.wr_fall = wr_prev_q & ~wr_q;
  assign pins.rd_fall = rd_prev_q & ~rd_q;
  assign pins.lanes = lanes_q;

endmodule : bdpm_pin_front
`default_nettype wire

// [verilog/bdpm_port.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Sync split: write on port clock edge when input enable on and not busy.
// - Sync split: advance output on port clock edge with output enable and available.
// - Async split: input words captured on the input enable strobe.
// - Async split: output word advances on each output enable strobe while a word is available.
// - Async split: output lanes released while output enable is off.
// - Mixed: input via enable strobe when not busy; output with enable and available.
// - 8-bit sync bidir, enable on: low lanes input, written when enabled and not busy.
// - 8-bit sync bidir, enable off: drive low lanes, advance with enable and available.
// - Sync bidir modes may take direction from the configuration direction bit.
// - Handshake modes take direction only from the configuration direction bit.
// - 8-bit handshake write: low lanes captured on write strobe.
// - 8-bit handshake read: drive low lanes, advance on read strobe.
// - 8-bit handshake: upper lanes always released.
// - Fully async: write on input enable strobe, advance on output enable strobe.
// - 16-bit sync bidir, enable on: all lanes input, written when enabled, not busy.
// - 16-bit sync bidir, enable off: drive all lanes, advance with enable, available.
// - 16-bit handshake write: all lanes captured on write strobe.
// - 16-bit handshake read: drive all lanes, advance on read strobe.
// - Busy, available and enable polarities each follow a polarity bit.
module bdpm_port
  import bdpm_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Configuration levels.
  input wire logic [2:0] port_mode_sel,
  input wire logic transfer_direction_bit,
  input wire logic dir_from_config,
  input wire logic busy_polarity_bit,
  input wire logic avail_polarity_bit,
  input wire logic out_enable_polarity_bit,
  input wire logic in_enable_polarity_bit,
  // Port pins.
  input wire logic port_input_clock,
  input wire logic input_strobe_enable,
  input wire logic output_strobe_enable,
  input wire logic handshake_write_strobe,
  input wire logic handshake_read_strobe,
  input wire logic [15:0] port_data_lanes_in,
  output logic [15:0] port_data_lanes_out,
  output logic [15:0] port_data_lanes_oe,
  output logic input_busy_flag,
  output logic output_available_flag,
  // Internal FIFO, fill side.
  output logic fifo_wr_valid,
  output logic [15:0] fifo_wr_data,
  output logic fifo_wr_wide,
  input wire logic fifo_wr_ready,
  // Internal FIFO, drain side.
  input wire logic fifo_rd_valid,
  input wire logic [15:0] fifo_rd_data,
  output logic fifo_rd_take
);

  bdpm_pin_if pins ();

  bdpm_pin_front u_front (
    .core_clk(core_clk),
    .rstn(rstn),
    .port_input_clock(port_input_clock),
    .input_strobe_enable(input_strobe_enable),
    .output_strobe_enable(output_strobe_enable),
    .handshake_write_strobe(handshake_write_strobe),
    .handshake_read_strobe(handshake_read_strobe),
    .port_data_lanes_in(port_data_lanes_in),
    .out_enable_polarity_bit(out_enable_polarity_bit),
    .in_enable_polarity_bit(in_enable_polarity_bit),
    .pins(pins)
  );

  bdpm_mode_type mode;
  logic busy_q, avail_q;
  logic wr_valid_q, wr_wide_q, rd_take_q;
  logic [15:0] wr_data_q, lanes_out_q, lanes_oe_q;
  logic busy_pin_q, avail_pin_q;

  assign mode = bdpm_decode_mode(port_mode_sel);

  wire m_a = (mode == BDPM_M_SYNC_SPLIT);
  wire m_b = (mode == BDPM_M_ASYNC_SPLIT);
  wire m_c = (mode == BDPM_M_MIXED);
  wire m_d = (mode == BDPM_M_SYNC_BI8);
  wire m_e = (mode == BDPM_M_HSK8);
  wire m_f = (mode == BDPM_M_ASYNC_FULL);
  wire m_g = (mode == BDPM_M_SYNC_BI16);
  wire m_h = (mode == BDPM_M_HSK16);
  wire sync_bi = m_d | m_g;
  wire hsk = m_e | m_h;
  wire wide = m_g | m_h;

  // Direction of the sync bidir modes: enable pin, or the configuration bit when selected.
  wire sync_dir_in = dir_from_config ? transfer_direction_bit : pins.oen_act;
  // Handshake direction never looks at a pin.
  wire handshake_direction = transfer_direction_bit;

  wire sync_ok = pins.pclk_rise & pins.ien_act & ~busy_q;
  wire wr_a = m_a & sync_ok;
  wire wr_async = (m_b | m_f) & pins.ien_rise;
  wire wr_c = m_c & pins.ien_rise & ~busy_q;
  wire wr_sync_bi = sync_bi & sync_dir_in & sync_ok;
  // A 16-bit handshake write is taken as one word; the far party keeps it aligned.
  wire wr_hsk = hsk & handshake_direction & pins.wr_fall;
  wire wr_fire = wr_a | wr_async | wr_c | wr_sync_bi | wr_hsk;

  // The drain is only popped while a word is shown as available.
  wire rd_split = (m_a | m_c) & pins.pclk_rise & pins.oen_act & avail_q;
  wire rd_async = (m_b | m_f) & pins.oen_rise & avail_q;
  wire rd_sync_bi = sync_bi & ~sync_dir_in & pins.pclk_rise & pins.ien_act & avail_q;
  wire rd_hsk = hsk & ~handshake_direction & pins.rd_fall & avail_q;
  wire rd_fire = rd_split | rd_async | rd_sync_bi | rd_hsk;

  wire [15:0] wr_word = wide ? pins.lanes : {8'h00, pins.lanes[7:0]};
  wire split_out = m_a | m_b | m_c | m_f;
  wire [15:0] out_word = wide ? fifo_rd_data :
    (split_out ? {fifo_rd_data[7:0], 8'h00} : {8'h00, fifo_rd_data[7:0]});

  wire split_drive = m_a | m_c | m_f | (m_b & pins.oen_act);
  wire bi_drive = (sync_bi & ~sync_dir_in) | (hsk & ~handshake_direction);
  // Narrow bidir and handshake modes never touch the upper lanes.
  wire [15:0] bi_mask = wide ? BDPM_ALL_LANES : BDPM_LOW_LANES;
  wire [15:0] oe_word = split_drive ? BDPM_HIGH_LANES : (bi_drive ? bi_mask : BDPM_OE_RST);

  wire busy_d = ~fifo_wr_ready;
  wire busy_pin_d = busy_polarity_bit ? busy_d : ~busy_d;
  wire avail_pin_d = avail_polarity_bit ? fifo_rd_valid : ~fifo_rd_valid;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_q <= BDPM_FLAG_RST;
      avail_q <= BDPM_FLAG_RST;
      busy_pin_q <= BDPM_FLAG_RST;
      avail_pin_q <= BDPM_FLAG_RST;
    end
    else
    begin
      busy_q <= busy_d;
      avail_q <= fifo_rd_valid;
      busy_pin_q <= busy_pin_d;
      avail_pin_q <= avail_pin_d;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_valid_q <= BDPM_FLAG_RST;
      wr_wide_q <= BDPM_FLAG_RST;
      wr_data_q <= BDPM_WORD_RST;
      rd_take_q <= BDPM_FLAG_RST;
    end
    else
    begin
      wr_valid_q <= wr_fire;
      wr_wide_q <= wide;
      wr_data_q <= wr_fire ? wr_word : wr_data_q;
      rd_take_q <= rd_fire;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lanes_out_q <= BDPM_WORD_RST;
      lanes_oe_q <= BDPM_OE_RST;
    end
    else
    begin
      lanes_out_q <= out_word;
      lanes_oe_q <= oe_word;
    end
  end

  assign port_data_lanes_out = lanes_out_q;
  assign port_data_lanes_oe = lanes_oe_q;
  assign input_busy_flag = busy_pin_q;
  assign output_available_flag = avail_pin_q;
  assign fifo_wr_valid = wr_valid_q;
  assign fifo_wr_data = wr_data_q;
  assign fifo_wr_wide = wr_wide_q;
  assign fifo_rd_take = rd_take_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_SYNC_SPLIT_WRITE: assert property (
    (m_a && pins.pclk_rise && pins.ien_act && !busy_q)
      |=> (fifo_wr_valid && fifo_wr_data == {8'h00, $past(pins.lanes[7:0])})
  ) else $error("Sync split write not taken.");

  AST_SYNC_SPLIT_BUSY: assert property (
    (m_a && (busy_q || !pins.pclk_rise || !pins.ien_act)) |=> !fifo_wr_valid
  ) else $error("Sync split write taken while busy or idle.");

  AST_SYNC_SPLIT_READ: assert property (
    (m_a && $past(m_a)) |-> (fifo_rd_take == $past(pins.pclk_rise && pins.oen_act && avail_q))
  ) else $error("Sync split advance mismatch.");

  AST_ASYNC_SPLIT_WRITE: assert property (
    (m_b && $past(m_b)) |-> (fifo_wr_valid == $past(pins.ien_rise))
  ) else $error("Async split write not tied to input strobe.");

  AST_ASYNC_SPLIT_READ: assert property (
    (m_b && pins.oen_rise && avail_q) |=> fifo_rd_take ##1 !fifo_rd_take
  ) else $error("Async split advance is not one pulse per strobe.");

  AST_ASYNC_SPLIT_RELEASE: assert property (
    (m_b && !pins.oen_act) |=> (port_data_lanes_oe == 16'h0000)
  ) else $error("Async split lanes driven with output enable off.");

  AST_MIXED: assert property (
    (m_c && pins.ien_rise && !busy_q) |=> fifo_wr_valid
  ) else $error("Mixed mode write lost.");

  AST_MIXED_READ_GATE: assert property (
    (m_c && !avail_q) |=> !fifo_rd_take
  ) else $error("Mixed mode advance without available word.");

  AST_BI8_WRITE: assert property (
    (m_d && sync_dir_in && sync_ok) |=> (fifo_wr_valid && !fifo_wr_wide)
      && (port_data_lanes_oe == 16'h0000)
  ) else $error("8-bit bidir write wrong.");

  AST_BI8_DRIVE: assert property (
    (m_d && !sync_dir_in) |=> (port_data_lanes_oe == 16'h00ff)
      && (fifo_rd_take == $past(pins.pclk_rise && pins.ien_act && avail_q))
  ) else $error("8-bit bidir drive wrong.");

  AST_DIR_CONFIG: assert property (
    (sync_bi && dir_from_config && transfer_direction_bit) |=> (port_data_lanes_oe == 16'h0000)
  ) else $error("Configured write direction still drives lanes.");

  AST_HSK_DIR: assert property (
    (hsk && !transfer_direction_bit && !pins.rd_fall) |=> !fifo_wr_valid && !fifo_rd_take
  ) else $error("Handshake transfer without its strobe.");

  AST_HSK8_WRITE: assert property (
    (m_e && transfer_direction_bit && pins.wr_fall)
      |=> fifo_wr_valid && (fifo_wr_data[15:8] == 8'h00)
  ) else $error("8-bit handshake write wrong.");

  AST_HSK8_READ: assert property (
    (m_e && !transfer_direction_bit && pins.rd_fall && avail_q) |=> fifo_rd_take
  ) else $error("8-bit handshake read not advanced.");

  AST_HSK8_UPPER: assert property (
    m_e |=> (port_data_lanes_oe[15:8] == 8'h00)
  ) else $error("8-bit handshake drives upper lanes.");

  AST_FULL_ASYNC: assert property (
    (m_f && pins.ien_rise && !pins.oen_rise) |=> fifo_wr_valid && !fifo_rd_take
  ) else $error("Fully async strobes misrouted.");

  AST_BI16_WRITE: assert property (
    (m_g && sync_dir_in && sync_ok)
      |=> fifo_wr_valid && fifo_wr_wide && (fifo_wr_data == $past(pins.lanes))
  ) else $error("16-bit bidir write wrong.");

  AST_BI16_DRIVE: assert property (
    (m_g && !sync_dir_in) |=> (port_data_lanes_oe == 16'hffff)
      && (port_data_lanes_out == $past(fifo_rd_data))
  ) else $error("16-bit bidir drive wrong.");

  AST_HSK16_WRITE: assert property (
    (m_h && transfer_direction_bit && pins.wr_fall)
      |=> fifo_wr_valid && (fifo_wr_data == $past(pins.lanes))
  ) else $error("16-bit handshake write wrong.");

  AST_HSK16_READ: assert property (
    (m_h && !transfer_direction_bit && pins.rd_fall && avail_q)
      |=> fifo_rd_take && (port_data_lanes_oe == 16'hffff)
  ) else $error("16-bit handshake read wrong.");

  AST_BUSY_POLARITY: assert property (
    $stable(busy_polarity_bit) && $stable(fifo_wr_ready)
      |=> (input_busy_flag == ($past(busy_polarity_bit) ^ $past(fifo_wr_ready)))
  ) else $error("Busy pin polarity wrong.");

  AST_AVAIL_POLARITY: assert property (
    $stable(avail_polarity_bit) && $stable(fifo_rd_valid)
      |=> (output_available_flag == !($past(avail_polarity_bit) ^ $past(fifo_rd_valid)))
  ) else $error("Available pin polarity wrong.");

  // Read gates: no pop is asked for while the head is shown empty.
  AST_SYNC_SPLIT_IDLE: assert property (
    (m_a && !avail_q) |=> !fifo_rd_take
  ) else $error("Sync split advance without available word.");

  AST_SPLIT_DRIVE: assert property (
    m_a |=> (port_data_lanes_oe == 16'hff00)
  ) else $error("Sync split output lanes wrong.");

  AST_ASYNC_SPLIT_OUT: assert property (
    m_b |=> (port_data_lanes_out == {$past(fifo_rd_data[7:0]), 8'h00})
  ) else $error("Async split output word wrong.");

  AST_MIXED_DRIVE: assert property (
    m_c |=> (port_data_lanes_oe == 16'hff00)
  ) else $error("Mixed mode output lanes wrong.");

  AST_BI8_READ_GATE: assert property (
    (m_d && !avail_q) |=> !fifo_rd_take
  ) else $error("8-bit bidir advance without available word.");

  AST_SYNC_DIR_PIN: assert property (
    (sync_bi && !dir_from_config && pins.oen_act) |=> (port_data_lanes_oe == 16'h0000)
  ) else $error("Enable pin input direction still drives lanes.");

  AST_HSK16_DIR: assert property (
    (m_h && transfer_direction_bit) |=> (port_data_lanes_oe == 16'h0000)
  ) else $error("16-bit handshake write direction drives lanes.");

  AST_HSK8_OUT: assert property (
    (m_e && !transfer_direction_bit)
      |=> (port_data_lanes_out == {8'h00, $past(fifo_rd_data[7:0])})
  ) else $error("8-bit handshake output word wrong.");

  AST_FULL_ASYNC_READ: assert property (
    (m_f && pins.oen_rise && avail_q) |=> fifo_rd_take
  ) else $error("Fully async advance lost.");

  AST_BI16_READ_GATE: assert property (
    (m_g && !avail_q) |=> !fifo_rd_take
  ) else $error("16-bit bidir advance without available word.");

  AST_HSK16_READ_GATE: assert property (
    (m_h && !avail_q) |=> !fifo_rd_take
  ) else $error("16-bit handshake advance without available word.");

endmodule : bdpm_port
`default_nettype wire

// [verif/bdpm_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Memory side of the port: each enable, strobe or clock change is held for at least three cycles.
module bdpm_mem_model (
  // Clock, polarity and resolved lanes.
  input wire logic core_clk,
  input wire logic in_pol,
  input wire logic out_pol,
  input wire logic [15:0] seen,
  // Pins toward the device.
  output logic port_input_clock,
  output logic input_strobe_enable,
  output logic output_strobe_enable,
  output logic handshake_write_strobe,
  output logic handshake_read_strobe,
  output logic [15:0] drv,
  output logic drv_en
);
  logic [15:0] data_q = 16'h0000;
  logic [15:0] last_q = 16'h0000;
  initial
  begin
    port_input_clock = 1'b0;
    input_strobe_enable = 1'b0;
    output_strobe_enable = 1'b0;
    handshake_write_strobe = 1'b1;
    handshake_read_strobe = 1'b1;
    drv_en = 1'b0;
  end
  // Released lanes show the inverse of the last wire value, so no stale data survives.
  assign drv = drv_en ? data_q : ~last_q;
  always @(posedge core_clk) last_q <= seen;
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_n
  task automatic level(input logic out_side, input logic on);
    @(posedge core_clk);
    if (out_side)
      output_strobe_enable <= on ? out_pol : ~out_pol;
    else
      input_strobe_enable <= on ? in_pol : ~in_pol;
    wait_n(3);
  endtask : level
  task automatic pclk_rise();
    @(posedge core_clk);
    port_input_clock <= 1'b1;
    wait_n(3);
    port_input_clock <= 1'b0;
    wait_n(3);
  endtask : pclk_rise
  // Each write strobe carries one whole aligned unit, never a split word.
  task automatic strobe(input logic rd);
    @(posedge core_clk);
    if (rd)
      handshake_read_strobe <= 1'b0;
    else
      handshake_write_strobe <= 1'b0;
    wait_n(3);
    handshake_read_strobe <= 1'b1;
    handshake_write_strobe <= 1'b1;
    wait_n(3);
  endtask : strobe
  task automatic put(input logic [15:0] d);
    @(posedge core_clk);
    data_q <= d;
    drv_en <= 1'b1;
  endtask : put
  task automatic release_lanes();
    @(posedge core_clk);
    drv_en <= 1'b0;
  endtask : release_lanes
endmodule : bdpm_mem_model
`default_nettype wire

// [verif/bdpm_port_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bdpm_port_bench import bdpm_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn, dir, dcfg, bpol, apol, ipol, opol, rdy, vld;
  logic [2:0] mode;
  logic [15:0] head;
  logic pclk, ien, oen, wr_n, rd_n, drv_en, busy, avail, wr_v, wide, take;
  logic [15:0] drv, lanes, lout, oe, wr_d;
  logic [15:0] wr_last = 16'h0000;
  int err_total = 0;
  int samples_checked = 0;
  int wr_cnt = 0, rd_cnt = 0, w0 = 0, r0 = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  assign lanes = (oe & lout) | (~oe & drv);
  bdpm_port uut (
    .core_clk(core_clk), .rstn(rstn), .port_mode_sel(mode), .transfer_direction_bit(dir),
    .dir_from_config(dcfg), .busy_polarity_bit(bpol), .avail_polarity_bit(apol),
    .out_enable_polarity_bit(opol), .in_enable_polarity_bit(ipol), .port_input_clock(pclk),
    .input_strobe_enable(ien), .output_strobe_enable(oen), .handshake_write_strobe(wr_n),
    .handshake_read_strobe(rd_n), .port_data_lanes_in(lanes), .port_data_lanes_out(lout),
    .port_data_lanes_oe(oe), .input_busy_flag(busy), .output_available_flag(avail),
    .fifo_wr_valid(wr_v), .fifo_wr_data(wr_d), .fifo_wr_wide(wide), .fifo_wr_ready(rdy),
    .fifo_rd_valid(vld), .fifo_rd_data(head), .fifo_rd_take(take)
  );
  bdpm_mem_model mem (
    .core_clk(core_clk), .in_pol(ipol), .out_pol(opol), .seen(lanes), .port_input_clock(pclk),
    .input_strobe_enable(ien), .output_strobe_enable(oen), .handshake_write_strobe(wr_n),
    .handshake_read_strobe(rd_n), .drv(drv), .drv_en(drv_en)
  );
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (wr_v === 1'b1)
    begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= wr_d;
    end
    if (take === 1'b1)
      rd_cnt <= rd_cnt + 1;
    if (cyc == 4000)
    begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task automatic check_bit(input string what, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask : check_bit
  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_word
  // Counts the FIFO pulses since the last call; stray pulses fail here too.
  task automatic got(input int nw, input int nr, input logic [15:0] d);
    mem.wait_n(8);
    check_word("writes", 16'(nw), 16'(wr_cnt - w0));
    check_word("reads", 16'(nr), 16'(rd_cnt - r0));
    if (nw > 0)
      check_word("wdata", d, wr_last);
    w0 = wr_cnt;
    r0 = rd_cnt;
  endtask : got
  task automatic cfg(input logic [2:0] m, input logic d, input logic c);
    @(posedge core_clk);
    mode <= m;
    dir <= d;
    dcfg <= c;
    mem.wait_n(4);
  endtask : cfg
  task automatic fifo(input logic r, input logic v, input logic [15:0] h);
    @(posedge core_clk);
    rdy <= r;
    vld <= v;
    head <= h;
    mem.wait_n(4);
  endtask : fifo
  task automatic t_sync_split();
    cfg(BDPM_SEL_SYNC_SPLIT, 1'b0, 1'b0);
    mem.put(16'h005a);
    mem.level(1'b0, 1'b1);
    mem.pclk_rise();
    got(1, 0, 16'h005a);
    fifo(1'b0, 1'b0, 16'h0000);
    check_bit("busy", 1'b1, busy);
    mem.pclk_rise();
    got(0, 0, 16'h0000);
    mem.level(1'b0, 1'b0);
    mem.release_lanes();
    fifo(1'b1, 1'b1, 16'h1234);
    check_bit("avail", 1'b1, avail);
    check_word("out", 16'h3400, lout);
    mem.level(1'b1, 1'b1);
    mem.pclk_rise();
    got(0, 1, 16'h0000);
    check_word("oe", BDPM_HIGH_LANES, oe);
    fifo(1'b1, 1'b0, 16'h0000);
    mem.pclk_rise();
    got(0, 0, 16'h0000);
    mem.level(1'b1, 1'b0);
    $display("test sync_split done");
  endtask : t_sync_split
  task automatic t_polarity();
    @(posedge core_clk);
    {bpol, apol, ipol, opol} <= 4'h0;
    mem.level(1'b0, 1'b0);
    mem.level(1'b1, 1'b0);
    fifo(1'b1, 1'b1, 16'h0000);
    check_bit("busy", 1'b1, busy);
    check_bit("avail", 1'b0, avail);
    mem.put(16'h0081);
    mem.level(1'b0, 1'b1);
    mem.pclk_rise();
    mem.level(1'b0, 1'b0);
    got(1, 0, 16'h0081);
    mem.level(1'b1, 1'b1);
    mem.pclk_rise();
    mem.level(1'b1, 1'b0);
    got(0, 1, 16'h0000);
    @(posedge core_clk);
    {bpol, apol, ipol, opol} <= 4'hf;
    mem.level(1'b0, 1'b0);
    mem.level(1'b1, 1'b0);
    fifo(1'b1, 1'b0, 16'h0000);
    mem.release_lanes();
    $display("test polarity done");
  endtask : t_polarity
  task automatic t_async_split();
    cfg(BDPM_SEL_ASYNC_SPLIT, 1'b0, 1'b0);
    check_word("oe", 16'h0000, oe);
    mem.put(16'h00c3);
    mem.level(1'b0, 1'b1);
    mem.level(1'b0, 1'b0);
    got(1, 0, 16'h00c3);
    mem.release_lanes();
    fifo(1'b1, 1'b1, 16'h00aa);
    mem.level(1'b1, 1'b1);
    check_word("oe", BDPM_HIGH_LANES, oe);
    check_word("out", 16'haa00, lout);
    mem.level(1'b1, 1'b0);
    got(0, 1, 16'h0000);
    check_word("oe", 16'h0000, oe);
    $display("test async_split done");
  endtask : t_async_split
  task automatic t_mixed_full();
    cfg(BDPM_SEL_MIXED, 1'b0, 1'b0);
    fifo(1'b0, 1'b0, 16'h0000);
    mem.put(16'h0011);
    mem.level(1'b0, 1'b1);
    mem.level(1'b0, 1'b0);
    got(0, 0, 16'h0000);
    fifo(1'b1, 1'b1, 16'h0022);
    mem.level(1'b0, 1'b1);
    mem.level(1'b0, 1'b0);
    got(1, 0, 16'h0011);
    mem.level(1'b1, 1'b1);
    mem.pclk_rise();
    mem.level(1'b1, 1'b0);
    got(0, 1, 16'h0000);
    cfg(BDPM_SEL_ASYNC_FULL, 1'b0, 1'b0);
    mem.level(1'b0, 1'b1);
    mem.level(1'b0, 1'b0);
    got(1, 0, 16'h0011);
    mem.level(1'b1, 1'b1);
    mem.level(1'b1, 1'b0);
    got(0, 1, 16'h0000);
    mem.release_lanes();
    fifo(1'b1, 1'b0, 16'h0000);
    $display("test mixed_full done");
  endtask : t_mixed_full
  task automatic t_sync_bidir();
    logic [2:0] m;
    logic [15:0] k;
    for (int i = 0; i < 2; i++)
    begin
      m = (i == 1) ? BDPM_SEL_SYNC_BI16 : BDPM_SEL_SYNC_BI8;
      k = (i == 1) ? BDPM_ALL_LANES : BDPM_LOW_LANES;
      cfg(m, 1'b0, 1'b0);
      mem.put(16'ha55a);
      mem.level(1'b1, 1'b1);
      mem.level(1'b0, 1'b1);
      mem.pclk_rise();
      mem.level(1'b0, 1'b0);
      got(1, 0, 16'ha55a & k);
      check_bit("wide", (i == 1), wide);
      check_word("oe", 16'h0000, oe & k);
      mem.release_lanes();
      mem.level(1'b1, 1'b0);
      fifo(1'b1, 1'b1, 16'h3cc3);
      check_word("oe", k, oe & k);
      check_word("out", 16'h3cc3 & k, lout & k);
      mem.level(1'b0, 1'b1);
      mem.pclk_rise();
      mem.level(1'b0, 1'b0);
      got(0, 1, 16'h0000);
      mem.level(1'b1, 1'b1);
      cfg(m, 1'b0, 1'b1);
      check_word("oe", k, oe & k);
      mem.level(1'b1, 1'b0);
      cfg(m, 1'b1, 1'b1);
      check_word("oe", 16'h0000, oe & k);
      fifo(1'b1, 1'b0, 16'h0000);
    end
    $display("test sync_bidir done");
  endtask : t_sync_bidir
  task automatic t_handshake();
    logic [2:0] m;
    logic [15:0] k;
    for (int i = 0; i < 2; i++)
    begin
      m = (i == 1) ? BDPM_SEL_HSK16 : BDPM_SEL_HSK8;
      k = (i == 1) ? BDPM_ALL_LANES : BDPM_LOW_LANES;
      cfg(m, 1'b1, 1'b0);
      mem.put(16'h9669);
      mem.strobe(1'b0);
      got(1, 0, 16'h9669 & k);
      check_bit("wide", (i == 1), wide);
      check_word("oe", 16'h0000, oe);
      mem.release_lanes();
      mem.level(1'b1, 1'b1);
      cfg(m, 1'b0, 1'b0);
      fifo(1'b1, 1'b1, 16'h5aa5);
      check_word("oe", k, oe);
      check_word("out", 16'h5aa5 & k, lout & k);
      mem.strobe(1'b1);
      got(0, 1, 16'h0000);
      mem.level(1'b1, 1'b0);
      fifo(1'b1, 1'b0, 16'h0000);
    end
    $display("test handshake done");
  endtask : t_handshake
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {rstn, dir, dcfg, vld} <= 4'h0;
    {bpol, apol, ipol, opol, rdy} <= 5'h1f;
    mode <= BDPM_SEL_SYNC_SPLIT;
    head <= 16'h0000;
    mem.wait_n(16);
    rstn <= 1'b1;
    mem.wait_n(4);
    t_sync_split();
    t_polarity();
    t_async_split();
    t_mixed_full();
    t_sync_bidir();
    t_handshake();
    report_and_stop();
  end
endmodule : bdpm_port_bench
`default_nettype wire
